//--- rtl/can_phy_mode_control.sv
// Mode and fault control of an on-chip CAN physical layer.
// Assumes the analog comparators deliver asynchronous fault levels and the
// receiver comparator delivers an asynchronous dominant level.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Transmit input high recessive, low dominant
// - Receive output high recessive, low dominant
// - Normal mode enables all five fault monitors
// - High voltage, overcurrent, timeout enter listen-only
// - CANL low voltage sets flag, pseudo-normal
// - CANH low voltage keeps normal mode
// - Pseudo-normal disables only CANL driver
// - Pseudo-normal returns to normal when cleared
// - Listen-only forces transmitter fully off
// - Voltage-caused listen-only recovers automatically
// - Timeout flag clear ignored while dominant
// - Shutdown not re-entered until reset
module can_phy_mode_control
	import can_phy_pkg::*;
#(
	parameter int TX_TMO_LIMIT = can_phy_pkg::TX_TMO_CYCLES
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic [3:0]                  reg_addr,
	input  wire logic [7:0]                  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [7:0]                  reg_rdata,
	output logic                             irq,
	input  wire logic                        phy_tx_input,
	output logic                             phy_rx_output,
	input  wire logic                        bus_dominant_async,
	input  wire logic                        canl_low_async,
	input  wire logic                        canh_low_async,
	input  wire logic                        high_volt_async,
	input  wire logic                        over_cur_async,
	output logic                             canh_drive,
	output logic                             canl_drive,
	output logic                             monitors_en,
	output can_phy_pkg::phy_mode_t           mode
);
	import can_phy_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic       bus_dom;
	logic       canl_low;
	logic       canh_low;
	logic       high_volt;
	logic       over_cur;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end else begin
			sync1_reg <= {over_cur_async, high_volt_async, canh_low_async,
			              canl_low_async, bus_dominant_async};
			sync2_reg <= sync1_reg;
		end
	end

	assign bus_dom   = sync2_reg[0];
	assign canl_low  = sync2_reg[1];
	assign canh_low  = sync2_reg[2];
	assign high_volt = sync2_reg[3];
	assign over_cur  = sync2_reg[4];

	// ****************************************************************
	// Receive path
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst)
			phy_rx_output <= 1'b1;
		else
			phy_rx_output <= ~bus_dom;
	end

	// ****************************************************************
	// Transmit-dominant timeout counter
	// ****************************************************************
	logic [31:0] tmo_cnt_reg;
	logic        tx_tmo_event;
	phy_mode_t   mode_reg;
	logic        active_mode;

	assign active_mode = (mode_reg == MODE_NORMAL) || (mode_reg == MODE_PSEUDO)
	                     || (mode_reg == MODE_LISTEN);
	assign monitors_en = active_mode;

	// Counting stops at the limit so the event fires once per dominant stretch
	always_ff @(posedge core_clk) begin
		if (rst || phy_tx_input || !monitors_en)
			tmo_cnt_reg <= 32'h0;
		else if (tmo_cnt_reg < 32'(TX_TMO_LIMIT))
			tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
	end

	assign tx_tmo_event = monitors_en && (tmo_cnt_reg == 32'(TX_TMO_LIMIT) - 32'h1)
	                      && !phy_tx_input;

	// ****************************************************************
	// Fault flags and interrupt
	// ****************************************************************
	logic [FLAG_W-1:0] flag_reg;
	logic [FLAG_W-1:0] mask_reg;
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flag_clr;
	logic              low_line_undervoltage_flag;

	always_comb begin
		flag_set                 = '0;
		flag_set[FLAG_LOW_CANL]  = monitors_en && canl_low;
		flag_set[FLAG_LOW_CANH]  = monitors_en && canh_low;
		flag_set[FLAG_HIGH_VOLT] = monitors_en && high_volt;
		flag_set[FLAG_OVER_CUR]  = monitors_en && over_cur;
		flag_set[FLAG_TX_TMO]    = tx_tmo_event;
		flag_clr = (reg_wr && reg_addr == ADDR_STATUS) ? reg_wdata[FLAG_W-1:0] : '0;
		// Clearing the timeout flag is refused while the input is dominant
		if (!phy_tx_input)
			flag_clr[FLAG_TX_TMO] = 1'b0;
	end

	// Set wins over a simultaneous clear
	always_ff @(posedge core_clk) begin
		if (rst)
			flag_reg <= FLAG_RESET;
		else
			flag_reg <= (flag_reg & ~flag_clr) | flag_set;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			mask_reg <= MASK_RESET;
		else if (reg_wr && reg_addr == ADDR_MASK)
			mask_reg <= reg_wdata[FLAG_W-1:0];
	end

	assign irq = |(flag_reg & mask_reg);
	assign low_line_undervoltage_flag = flag_reg[FLAG_LOW_CANL];

	// ****************************************************************
	// Mode state machine
	// ****************************************************************
	logic      shutdown_left_reg;
	phy_mode_t mode_next;
	logic      ctrl_shutdown_req;
	logic      ctrl_standby_req;
	logic      ctrl_wake_req;
	logic      listen_hold;

	assign ctrl_shutdown_req = reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[CTRL_SHUTDOWN];
	assign ctrl_standby_req  = reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[CTRL_STANDBY];
	assign ctrl_wake_req     = reg_wr && reg_addr == ADDR_CONTROL
	                           && !reg_wdata[CTRL_SHUTDOWN] && !reg_wdata[CTRL_STANDBY];

	// Listen-only persists while a high-voltage fault is live, or until software
	// clears the overcurrent and timeout flags.
	assign listen_hold = high_volt || flag_reg[FLAG_OVER_CUR]
	                     || flag_reg[FLAG_TX_TMO];

	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			MODE_SHUTDOWN: begin
				if (ctrl_wake_req)
					mode_next = MODE_NORMAL;
				else if (ctrl_standby_req)
					mode_next = MODE_STANDBY;
			end
			MODE_STANDBY: begin
				if (ctrl_shutdown_req && !shutdown_left_reg)
					mode_next = MODE_SHUTDOWN;
				else if (ctrl_wake_req)
					mode_next = MODE_NORMAL;
			end
			MODE_NORMAL, MODE_PSEUDO, MODE_LISTEN: begin
				if (ctrl_shutdown_req && !shutdown_left_reg)
					mode_next = MODE_SHUTDOWN;
				else if (ctrl_standby_req)
					mode_next = MODE_STANDBY;
				else if (high_volt || over_cur || tx_tmo_event
				         || (mode_reg == MODE_LISTEN && listen_hold))
					mode_next = MODE_LISTEN;
				else if (canl_low)
					mode_next = MODE_PSEUDO;
				else
					mode_next = MODE_NORMAL;
			end
			default: mode_next = MODE_SHUTDOWN;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			mode_reg <= MODE_RESET;
		else
			mode_reg <= mode_next;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			shutdown_left_reg <= 1'b0;
		else if (mode_reg == MODE_SHUTDOWN && mode_next != MODE_SHUTDOWN)
			shutdown_left_reg <= 1'b1;
	end

	assign mode = mode_reg;

	// ****************************************************************
	// Driver control
	// ****************************************************************
	logic tx_dom;

	assign tx_dom = !phy_tx_input;
	always_comb begin
		canh_drive = 1'b0;
		canl_drive = 1'b0;
		unique case (mode_reg)
			MODE_NORMAL: begin
				canh_drive = tx_dom;
				canl_drive = tx_dom;
			end
			MODE_PSEUDO:
				canh_drive = tx_dom;
			MODE_LISTEN, MODE_SHUTDOWN, MODE_STANDBY: begin
				canh_drive = 1'b0;
				canl_drive = 1'b0;
			end
			default: begin
				canh_drive = 1'b0;
				canl_drive = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_STATUS:  reg_rdata <= {3'h0, flag_reg};
				ADDR_MASK:    reg_rdata <= {3'h0, mask_reg};
				ADDR_MODE:    reg_rdata <= {4'h0, shutdown_left_reg, mode_reg};
				default:      reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	listen_off_a: assert property (mode_reg == MODE_LISTEN |-> !canh_drive && !canl_drive)
		else $error("driver active in listen-only");
	pseudo_canl_a: assert property (mode_reg == MODE_PSEUDO |-> !canl_drive
	                                && canh_drive == !phy_tx_input)
		else $error("pseudo-normal drive wrong");
	normal_drive_a: assert property (mode_reg == MODE_NORMAL |-> canl_drive == !phy_tx_input)
		else $error("normal drive wrong");
	rx_follow_a: assert property (1'b1 |=> phy_rx_output == !$past(bus_dom))
		else $error("receive output wrong");
	fault_listen_a: assert property (active_mode && over_cur && !ctrl_shutdown_req
	                                 && !ctrl_standby_req |=> mode_reg == MODE_LISTEN)
		else $error("no listen-only on fault");
	canl_pseudo_a: assert property (mode_reg == MODE_NORMAL && canl_low && !high_volt
	                                && !over_cur && !tx_tmo_event && !reg_wr
	                                |=> mode_reg == MODE_PSEUDO && low_line_undervoltage_flag)
		else $error("no pseudo-normal on CANL fault");
	pseudo_back_a: assert property (mode_reg == MODE_PSEUDO && !canl_low && !high_volt
	                                && !over_cur && !tx_tmo_event && !reg_wr
	                                |=> mode_reg == MODE_NORMAL)
		else $error("no return from pseudo-normal");
	tmo_hold_a: assert property (flag_reg[FLAG_TX_TMO] && !phy_tx_input
	                             |=> flag_reg[FLAG_TX_TMO])
		else $error("timeout flag cleared while dominant");
	no_reshut_a: assert property (shutdown_left_reg |-> mode_reg != MODE_SHUTDOWN)
		else $error("shutdown re-entered");
	irq_level_a: assert property ((|(flag_set & mask_reg)) && !reg_wr |=> irq)
		else $error("interrupt not raised by unmasked flag");
	sticky_flag_a: assert property (flag_reg[FLAG_OVER_CUR] && !reg_wr
	                                |=> flag_reg[FLAG_OVER_CUR])
		else $error("flag lost without clear");
	mon_on_a: assert property (mode_reg == MODE_NORMAL && over_cur |=> flag_reg[FLAG_OVER_CUR])
		else $error("monitors off in normal");

	enter_listen_c: cover property (mode_reg == MODE_NORMAL ##1 mode_reg == MODE_LISTEN);
	enter_pseudo_c: cover property (mode_reg == MODE_NORMAL ##1 mode_reg == MODE_PSEUDO);
	tmo_flag_c:     cover property ($rose(flag_reg[FLAG_TX_TMO]));
	irq_c:          cover property ($rose(irq));

endmodule // can_phy_mode_control

`default_nettype wire

//--- rtl/can_phy_pkg.sv
// Constants for the CAN physical layer mode and fault controller.
// Assumes a single core clock of 25 MHz and a synchronous active-high reset.
package can_phy_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] ADDR_STATUS   = 4'h0;
	localparam logic [3:0] ADDR_MASK     = 4'h1;
	localparam logic [3:0] ADDR_MODE     = 4'h2;
	localparam logic [3:0] ADDR_CONTROL  = 4'h3;

	// ****************************************************************
	// Fault flag layout
	// ****************************************************************
	localparam int FLAG_W         = 5;
	localparam int FLAG_LOW_CANL  = 0;
	localparam int FLAG_LOW_CANH  = 1;
	localparam int FLAG_HIGH_VOLT = 2;
	localparam int FLAG_OVER_CUR  = 3;
	localparam int FLAG_TX_TMO    = 4;

	localparam logic [4:0] FLAG_RESET = 5'h00;
	localparam logic [4:0] MASK_RESET = 5'h00;

	// Control register bits
	localparam int CTRL_SHUTDOWN = 0;
	localparam int CTRL_STANDBY  = 1;

	typedef enum logic [2:0] {
		MODE_SHUTDOWN = 3'b000,
		MODE_NORMAL   = 3'b001,
		MODE_PSEUDO   = 3'b011,
		MODE_LISTEN   = 3'b010,
		MODE_STANDBY  = 3'b110
	} phy_mode_t;

	localparam phy_mode_t MODE_RESET = MODE_SHUTDOWN;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS  = 40;
	// Transmit-dominant timeout, least time before the monitor trips
	localparam int TX_TMO_US      = 500;
	localparam int TX_TMO_CYCLES  = (TX_TMO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- dv/can_bus_model.sv
// Far side of the transceiver: bus lines, other nodes and analog monitors.
// Assumes the bench sets the fault levels and the other nodes' dominant request.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bus and monitor model
// ****************************************************************
module can_bus_model (
	input  wire logic       canh_drive,
	input  wire logic       canl_drive,
	input  wire logic       other_dom,
	input  wire logic [3:0] fault_lv,
	output logic            bus_dominant_async,
	output logic            canl_low_async,
	output logic            canh_low_async,
	output logic            high_volt_async,
	output logic            over_cur_async
);
	// Levels lag the clock edge, as analog comparators would
	assign #7 bus_dominant_async = canh_drive | canl_drive | other_dom;
	assign #5 canl_low_async     = fault_lv[0];
	assign #5 canh_low_async     = fault_lv[1];
	assign #5 high_volt_async    = fault_lv[2];
	assign #5 over_cur_async     = fault_lv[3];
endmodule // can_bus_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the CAN physical layer mode controller.
// Assumes the bus model drives the analog levels seen by the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import can_phy_pkg::*;
	// Long enough that random dominant runs never trip the monitor
	localparam int TMO = 200;
	logic       core_clk     = 1'b0;
	logic       rst          = 1'b1;
	logic [3:0] reg_addr     = 4'h0;
	logic [7:0] reg_wdata    = 8'h00;
	logic       reg_wr       = 1'b0;
	logic       reg_rd       = 1'b0;
	logic       phy_tx_input = 1'b1;
	logic       other_dom    = 1'b0;
	logic [3:0] lv           = 4'h0;
	logic [7:0] reg_rdata, rv;
	logic       irq, phy_rx_output, bus_dom, canl_low, canh_low, high_volt, over_cur;
	logic       canh_drive, canl_drive, monitors_en, m_left;
	logic [4:0] m_flags, m_mask;
	phy_mode_t  mode, m_mode;
	int         num_errors = 0;
	int         n_compared = 0;

	always #20 core_clk = ~core_clk;

	can_phy_mode_control #(.TX_TMO_LIMIT(TMO)) dut (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .phy_tx_input(phy_tx_input),
		.phy_rx_output(phy_rx_output), .bus_dominant_async(bus_dom),
		.canl_low_async(canl_low), .canh_low_async(canh_low), .high_volt_async(high_volt),
		.over_cur_async(over_cur), .canh_drive(canh_drive), .canl_drive(canl_drive),
		.monitors_en(monitors_en), .mode(mode));
	can_bus_model bus (.canh_drive(canh_drive), .canl_drive(canl_drive),
		.other_dom(other_dom), .fault_lv(lv), .bus_dominant_async(bus_dom),
		.canl_low_async(canl_low), .canh_low_async(canh_low),
		.high_volt_async(high_volt), .over_cur_async(over_cur));

	// ****************************************************************
	// Reference model and checks
	// ****************************************************************
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_pin(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask
	function automatic void m_eval();
		if (m_mode inside {MODE_NORMAL, MODE_PSEUDO, MODE_LISTEN}) begin
			m_flags = m_flags | {1'b0, lv};
			m_mode = (lv[2] || m_flags[3] || m_flags[4]) ? MODE_LISTEN :
				(lv[0] ? MODE_PSEUDO : MODE_NORMAL);
		end
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (a == ADDR_STATUS) m_flags = m_flags & ~(d[4:0] & {phy_tx_input, 4'hf});
		if (a == ADDR_MASK) m_mask = d[4:0];
		if (a == ADDR_CONTROL) begin
			if (d[0]) begin
				if (!m_left) m_mode = MODE_SHUTDOWN;
			end else if (d[1]) begin
				m_left = m_left | (m_mode == MODE_SHUTDOWN);
				m_mode = MODE_STANDBY;
			end else if (m_mode inside {MODE_SHUTDOWN, MODE_STANDBY}) begin
				m_left = m_left | (m_mode == MODE_SHUTDOWN);
				m_mode = MODE_NORMAL;
			end
		end
		m_eval();
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask
	task automatic settle();
		repeat (6) @(posedge core_clk);
	endtask
	task automatic fault(input int i, input logic v);
		@(posedge core_clk);
		lv[i] <= v;
		settle();
		m_eval();
	endtask
	task automatic check_all();
		logic dh, dl;
		rd(ADDR_STATUS);
		chk_reg("status", {3'b000, m_flags}, rv);
		rd(ADDR_MODE);
		chk_reg("mode", {4'h0, m_left, m_mode}, rv);
		chk_reg("mode pin", {5'h00, m_mode}, {5'h00, mode});
		chk_pin("irq", |(m_flags & m_mask), irq);
		chk_pin("monitors", m_mode inside {MODE_NORMAL, MODE_PSEUDO, MODE_LISTEN}, monitors_en);
		dh = !phy_tx_input && (m_mode == MODE_NORMAL || m_mode == MODE_PSEUDO);
		dl = !phy_tx_input && m_mode == MODE_NORMAL;
		chk_pin("canh", dh, canh_drive);
		chk_pin("canl", dl, canl_drive);
		chk_pin("rx", !(dh || dl || other_dom), phy_rx_output);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		conclude();
	end
	initial begin
		void'($urandom(32'h788f));
		m_mode  = MODE_SHUTDOWN;
		m_flags = 5'h00;
		m_mask  = 5'h00;
		m_left  = 1'b0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		check_all();
		rd(4'h9);
		chk_reg("unmapped", 8'h00, rv);
		wr(ADDR_CONTROL, 8'h00);
		settle();
		check_all();
		$display("test wake done");
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			phy_tx_input <= 1'($urandom);
			other_dom    <= (i == 3);
			settle();
			check_all();
		end
		@(posedge core_clk);
		phy_tx_input <= 1'b1;
		other_dom    <= 1'b0;
		$display("test transfer done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_MASK, (i == 1) ? 8'h00 : {3'b000, 5'($urandom)});
			@(posedge core_clk);
			phy_tx_input <= 1'b0;
			other_dom    <= (i == 2);
			fault(i, 1'b1);
			check_all();
			fault(i, 1'b0);
			check_all();
			wr(ADDR_STATUS, 8'h1f);
			settle();
			check_all();
			@(posedge core_clk);
			phy_tx_input <= 1'b1;
			other_dom    <= 1'b0;
			$display("test fault %0d done", i);
		end
		wr(ADDR_MASK, 8'h10);
		@(posedge core_clk);
		phy_tx_input <= 1'b0;
		repeat (TMO + 4) @(posedge core_clk);
		m_flags[4] = 1'b1;
		m_eval();
		check_all();
		wr(ADDR_STATUS, 8'h10);
		settle();
		check_all();
		@(posedge core_clk);
		phy_tx_input <= 1'b1;
		wr(ADDR_STATUS, 8'h10);
		settle();
		check_all();
		$display("test timeout done");
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CONTROL, (i == 1) ? 8'h00 : 8'h02 >> (i / 2));
			settle();
			check_all();
		end
		$display("test shutdown done");
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		m_mode  = MODE_SHUTDOWN;
		m_flags = 5'h00;
		m_mask  = 5'h00;
		m_left  = 1'b0;
		check_all();
		$display("test reset done");
		conclude();
	end
endmodule // testbench
`default_nettype wire
